/* File: inc/cli_pkg.sv */
// Package for the camera-side pixel and trigger interface.
// Assumes one 25 MHz system clock; all camera and trigger input pins are asynchronous.
package cli_pkg;

	// ----------------------------------------------------------------
	// Clock rates
	// ----------------------------------------------------------------
	localparam int CLK_HZ      = 25_000_000;
	localparam int MCLK_MIN_HZ = 500_000;
	localparam int MCLK_MAX_HZ = 40_000_000;
	// Half-period divisor: f = CLK_HZ / (2 * (div + 1))
	localparam logic [15:0] MCLK_DIV_MAX = 16'(CLK_HZ / (2 * MCLK_MIN_HZ) - 1);
	localparam logic [15:0] MCLK_DIV_RST = MCLK_DIV_MAX;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_WSTART  = 8'h04;
	localparam logic [7:0] REG_WCOUNT  = 8'h08;
	localparam logic [7:0] REG_TRIG    = 8'h0C;
	localparam logic [7:0] REG_PULSE   = 8'h10;
	localparam logic [7:0] REG_MCLK0   = 8'h14;
	localparam logic [7:0] REG_MCLK1   = 8'h18;
	localparam logic [7:0] REG_CTLOUT  = 8'h1C;
	localparam logic [7:0] REG_STATUS  = 8'h20;
	localparam logic [7:0] REG_DATA    = 8'h24;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_CONT    = 0;
	localparam int CTRL_START   = 1;
	localparam int CTRL_FLD_EN  = 2;
	localparam int CTRL_FLD_SEL = 3;
	localparam int CTRL_TMASK   = 4;
	localparam int CTRL_QMASK   = 8;
	localparam int CTRL_POL     = 12;
	localparam int TRIG_DIR     = 0;
	localparam int TRIG_FALL    = 4;
	localparam int TRIG_LVL     = 8;
	localparam int TRIG_MODE    = 12;
	localparam int TRIG_EVSEL   = 20;
	localparam int CTLO_LVL     = 0;
	localparam int CTLO_DYN     = 4;
	localparam int STAT_OVF     = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] CTRL_RST   = 16'h0000;
	localparam logic [31:0] WSTART_RST = 32'h0000_0000;
	localparam logic [31:0] WCOUNT_RST = 32'hFFFF_FFFF;
	localparam logic [21:0] TRIG_RST   = 22'h00_0000;
	localparam logic [15:0] PULSE_RST  = 16'h0000;
	localparam logic [7:0]  CTLO_RST   = 8'h00;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	localparam logic [1:0] TMODE_LEVEL  = 2'h0;
	localparam logic [1:0] TMODE_STATUS = 2'h1;
	localparam logic [1:0] TMODE_PULSE  = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_CAPT = 2'b10
	} cli_acq_type;

endpackage

/* File: rtl/cli_fifo.sv */
// Word FIFO between pixel capture and the register read port.
// Assumes both sides on clk; the read word comes from an output register.
`timescale 1ns/1ns
module cli_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	// Filling side
	input  wire logic                     in_valid,
	output logic                          in_ready,
	input  wire logic [WIDTH-1:0]         in_data,
	// Draining side
	input  wire logic                     out_ready,
	output logic                          out_valid,
	output logic [WIDTH-1:0]              out_data,
	output logic [$clog2(DEPTH+1):0]      level
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wptr_ff, rptr_ff, nxt_wptr, nxt_rptr;
	logic [CW-1:0]    cnt_ff, nxt_cnt;
	logic             oval_ff, nxt_oval;
	logic [WIDTH-1:0] odat_ff, nxt_odat;
	logic             push, pull;

	assign in_ready  = (cnt_ff != CW'(DEPTH));
	assign out_valid = oval_ff;
	assign out_data  = odat_ff;
	assign level     = {1'b0, cnt_ff} + {{CW{1'b0}}, oval_ff};

	// ----------------------------------------------------------------
	// Pointers and output stage
	// ----------------------------------------------------------------
	// Output register refills whenever it is empty or being taken
	always_comb begin
		push     = in_valid && in_ready;
		pull     = (cnt_ff != '0) && (!oval_ff || out_ready);
		nxt_wptr = push ? AW'(wptr_ff + 1'b1) : wptr_ff;
		nxt_rptr = pull ? AW'(rptr_ff + 1'b1) : rptr_ff;
		nxt_cnt  = CW'(cnt_ff + CW'(push) - CW'(pull));
		nxt_odat = pull ? mem_ff[rptr_ff] : odat_ff;
		nxt_oval = pull ? 1'b1 : (out_ready ? 1'b0 : oval_ff);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			cnt_ff  <= '0;
			oval_ff <= 1'b0;
			odat_ff <= '0;
		end else begin
			wptr_ff <= nxt_wptr;
			rptr_ff <= nxt_rptr;
			cnt_ff  <= nxt_cnt;
			oval_ff <= nxt_oval;
			odat_ff <= nxt_odat;
		end
	end

	// Storage has no reset; only written words are ever read
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wptr_ff] <= in_data;
		end
	end
endmodule

/* File: rtl/cli_io.sv */
// Camera-side pixel capture, trigger lines, control lines and master clocks.
// Assumes clk at 25 MHz; pixel clock, data, enables and triggers are async pins.
`timescale 1ns/1ns

// Behaviour
// R1: Pixel data sampled on camera pixel clock edges
// R2: Up to 16 data bits, one word per edge
// R3: Four enable inputs qualify the pixel stream
// R4: Camera wires its field signal to enable C
// R5: Trigger lines start acquisition or drive outputs
// R6: Trigger input edge programmable rising or falling
// R7: Trigger output: level, status event or pulse
// R8: Two master clocks, 500 kHz up to 40 MHz; here at most 12.5 MHz (divisor 0)
// R9: Control outputs carry static level or pulse
// R10: First pixel/line counted from enable assertion edges
// R11: Per-line direction bit; input disables drive
module cli_io #(
	parameter int DATA_W     = 16,
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// Register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata,
	// Camera pins
	input  wire logic              cam_pclk,
	input  wire logic [DATA_W-1:0] cam_data,
	input  wire logic [3:0]        cam_ena,
	output logic [3:0]             cam_ctl,
	output logic [1:0]             cam_mclk,
	// External trigger pins
	input  wire logic [3:0]        trig_in,
	output logic [3:0]             trig_out,
	output logic [3:0]             trig_oe
);
	localparam int SW = DATA_W + 9;
	localparam int LW = $clog2(FIFO_DEPTH+1) + 1;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [SW-1:0]     s1_ff, s2_ff, nxt_s1, nxt_s2;
	logic [8:0]        s3_ff, nxt_s3;
	logic [DATA_W-1:0] data_s;
	logic              pclk_s, pclk_rise;
	logic [3:0]        ena_s, trig_s, trig_d, trig_rise, trig_fall;

	// Data shares the pclk path so word and edge stay aligned
	always_comb begin
		nxt_s1 = {trig_in, cam_ena, cam_pclk, cam_data};
		nxt_s2 = s1_ff;
		nxt_s3 = s2_ff[SW-1:DATA_W];
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= nxt_s1;
			s2_ff <= nxt_s2;
			s3_ff <= nxt_s3;
		end
	end

	assign data_s    = s2_ff[DATA_W-1:0];
	assign pclk_s    = s2_ff[DATA_W];
	assign ena_s     = s2_ff[DATA_W+4:DATA_W+1];
	assign trig_s    = s2_ff[DATA_W+8:DATA_W+5];
	assign trig_d    = s3_ff[8:5];
	assign pclk_rise = pclk_s && !s3_ff[0]; // R1
	assign trig_rise = trig_s & ~trig_d;
	assign trig_fall = ~trig_s & trig_d;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [15:0] ctrl_ff, nxt_ctrl;
	logic [31:0] wstart_ff, nxt_wstart, wcount_ff, nxt_wcount, rdata_ff, nxt_rdata;
	logic [21:0] tcfg_ff, nxt_tcfg;
	logic [15:0] pw_ff, nxt_pw;
	logic [15:0] mdiv_ff [2];
	logic [15:0] nxt_mdiv [2];
	logic [7:0]  ctlo_ff, nxt_ctlo;
	logic        ovf_ff, nxt_ovf, soft_start, cap_ok;
	logic        fifo_ready, fifo_wr, fifo_ovalid, fifo_pop;
	logic [DATA_W-1:0] fifo_odata;
	logic [LW-1:0]     fifo_level;
	cli_pkg::cli_acq_type st_ff, nxt_st;

	assign soft_start = reg_wr && (reg_addr == cli_pkg::REG_CTRL)
		&& reg_wdata[cli_pkg::CTRL_START];
	assign fifo_pop   = reg_rd && (reg_addr == cli_pkg::REG_DATA) && fifo_ovalid;
	assign reg_rdata  = rdata_ff;

	// Writes, overflow flag and read mux; divisors clamp to the slowest rate
	always_comb begin
		nxt_ctrl   = ctrl_ff;
		nxt_wstart = wstart_ff;
		nxt_wcount = wcount_ff;
		nxt_tcfg   = tcfg_ff;
		nxt_pw     = pw_ff;
		nxt_mdiv   = mdiv_ff;
		nxt_ctlo   = ctlo_ff;
		nxt_ovf    = ovf_ff;
		nxt_rdata  = 32'h0000_0000;
		if (reg_wr) begin
			case (reg_addr)
				cli_pkg::REG_CTRL:   nxt_ctrl   = reg_wdata[15:0] & 16'hFFFD;
				cli_pkg::REG_WSTART: nxt_wstart = reg_wdata;
				cli_pkg::REG_WCOUNT: nxt_wcount = reg_wdata;
				cli_pkg::REG_TRIG:   nxt_tcfg   = reg_wdata[21:0];
				cli_pkg::REG_PULSE:  nxt_pw     = reg_wdata[15:0];
				cli_pkg::REG_MCLK0:  nxt_mdiv[0] = (reg_wdata[15:0] > cli_pkg::MCLK_DIV_MAX)
					? cli_pkg::MCLK_DIV_MAX : reg_wdata[15:0]; // R8
				cli_pkg::REG_MCLK1:  nxt_mdiv[1] = (reg_wdata[15:0] > cli_pkg::MCLK_DIV_MAX)
					? cli_pkg::MCLK_DIV_MAX : reg_wdata[15:0]; // R8
				cli_pkg::REG_CTLOUT: nxt_ctlo   = reg_wdata[7:0];
				cli_pkg::REG_STATUS: if (reg_wdata[cli_pkg::STAT_OVF]) nxt_ovf = 1'b0;
				default: ;
			endcase
		end
		// Overflow set beats a same-cycle clear
		if (cap_ok && !fifo_ready) begin
			nxt_ovf = 1'b1;
		end
		if (reg_rd) begin
			case (reg_addr)
				cli_pkg::REG_CTRL:   nxt_rdata = {16'h0000, ctrl_ff};
				cli_pkg::REG_WSTART: nxt_rdata = wstart_ff;
				cli_pkg::REG_WCOUNT: nxt_rdata = wcount_ff;
				cli_pkg::REG_TRIG:   nxt_rdata = {10'h000, tcfg_ff};
				cli_pkg::REG_PULSE:  nxt_rdata = {16'h0000, pw_ff};
				cli_pkg::REG_MCLK0:  nxt_rdata = {16'h0000, mdiv_ff[0]};
				cli_pkg::REG_MCLK1:  nxt_rdata = {16'h0000, mdiv_ff[1]};
				cli_pkg::REG_CTLOUT: nxt_rdata = {24'h00_0000, ctlo_ff};
				cli_pkg::REG_STATUS: nxt_rdata = 32'({fifo_level, ena_s, trig_s, ovf_ff, st_ff});
				cli_pkg::REG_DATA:   nxt_rdata = 32'({fifo_ovalid, fifo_odata});
				default:             nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_ff    <= cli_pkg::CTRL_RST;
			wstart_ff  <= cli_pkg::WSTART_RST;
			wcount_ff  <= cli_pkg::WCOUNT_RST;
			tcfg_ff    <= cli_pkg::TRIG_RST;
			pw_ff      <= cli_pkg::PULSE_RST;
			mdiv_ff[0] <= cli_pkg::MCLK_DIV_RST;
			mdiv_ff[1] <= cli_pkg::MCLK_DIV_RST;
			ctlo_ff    <= cli_pkg::CTLO_RST;
			ovf_ff     <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
		end else begin
			ctrl_ff    <= nxt_ctrl;
			wstart_ff  <= nxt_wstart;
			wcount_ff  <= nxt_wcount;
			tcfg_ff    <= nxt_tcfg;
			pw_ff      <= nxt_pw;
			mdiv_ff    <= nxt_mdiv;
			ctlo_ff    <= nxt_ctlo;
			ovf_ff     <= nxt_ovf;
			rdata_ff   <= nxt_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Enable qualification, window counters and acquisition control
	// ----------------------------------------------------------------
	logic [3:0]  act, pena_ff, nxt_pena, tdir, trig_hit;
	logic [15:0] pix_ff, nxt_pix, line_ff, nxt_line, pix_cur, pulse_ff, nxt_pulse;
	logic        frame_rise, frame_fall, line_rise, field_ok, qual_ok;
	logic        in_pix, in_line, start_evt, go_frame, pulse_act;

	assign act        = ena_s ^ ctrl_ff[cli_pkg::CTRL_POL +: 4];
	assign frame_rise = pclk_rise && act[0] && !pena_ff[0];
	assign frame_fall = pclk_rise && !act[0] && pena_ff[0];
	assign line_rise  = pclk_rise && act[1] && !pena_ff[1];
	// Enable C is the field indicator
	assign field_ok   = !ctrl_ff[cli_pkg::CTRL_FLD_EN]
		|| (act[2] == ctrl_ff[cli_pkg::CTRL_FLD_SEL]); // R4
	assign qual_ok    = &(~ctrl_ff[cli_pkg::CTRL_QMASK +: 4] | act); // R3
	assign tdir       = tcfg_ff[cli_pkg::TRIG_DIR +: 4];
	assign trig_hit   = ~tdir & ctrl_ff[cli_pkg::CTRL_TMASK +: 4]
		& ((tcfg_ff[cli_pkg::TRIG_FALL +: 4] & trig_fall)
		| (~tcfg_ff[cli_pkg::TRIG_FALL +: 4] & trig_rise)); // R5 R6 R11
	assign start_evt  = soft_start || (|trig_hit);
	assign go_frame   = (st_ff == cli_pkg::ST_WAIT) && frame_rise && field_ok;
	assign pix_cur    = line_rise ? 16'h0000 : pix_ff; // R10
	assign in_pix     = (pix_cur >= wstart_ff[15:0])
		&& (16'(pix_cur - wstart_ff[15:0]) < wcount_ff[15:0]); // R10
	assign in_line    = (nxt_line >= wstart_ff[31:16])
		&& (16'(nxt_line - wstart_ff[31:16]) < wcount_ff[31:16]); // R10
	assign cap_ok     = pclk_rise && act[0] && act[1] && qual_ok && in_pix && in_line
		&& ((st_ff == cli_pkg::ST_CAPT) || go_frame); // R1 R3
	assign fifo_wr    = cap_ok && fifo_ready;
	assign pulse_act  = (pulse_ff != 16'h0000);

	// Pixel and line counters move only on sampled pixel clock edges; the pulse counter every clk
	always_comb begin
		nxt_pena  = pena_ff;
		nxt_pix   = pix_ff;
		nxt_line  = line_ff;
		nxt_st    = st_ff;
		nxt_pulse = pulse_act ? 16'(pulse_ff - 16'h0001) : 16'h0000;
		if (pclk_rise) begin
			nxt_pena = act;
			nxt_pix  = 16'(pix_cur + 16'h0001);
			if (line_rise) begin
				nxt_line = frame_rise ? 16'h0000 : 16'(line_ff + 16'h0001);
			end else if (frame_rise) begin
				nxt_line = 16'hFFFF;
			end
		end
		case (st_ff)
			cli_pkg::ST_IDLE: if (start_evt) nxt_st = cli_pkg::ST_WAIT; // R5
			cli_pkg::ST_WAIT: if (go_frame) nxt_st = cli_pkg::ST_CAPT;
			cli_pkg::ST_CAPT: if (frame_fall) nxt_st = ctrl_ff[cli_pkg::CTRL_CONT]
				? cli_pkg::ST_WAIT : cli_pkg::ST_IDLE;
			default:          nxt_st = cli_pkg::ST_IDLE;
		endcase
		// Shutter pulse starts with the captured frame
		if (go_frame) begin
			nxt_pulse = pw_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pena_ff  <= 4'h0;
			pix_ff   <= 16'h0000;
			line_ff  <= 16'hFFFF;
			st_ff    <= cli_pkg::ST_IDLE;
			pulse_ff <= 16'h0000;
		end else begin
			pena_ff  <= nxt_pena;
			pix_ff   <= nxt_pix;
			line_ff  <= nxt_line;
			st_ff    <= nxt_st;
			pulse_ff <= nxt_pulse;
		end
	end

	// ----------------------------------------------------------------
	// Pixel FIFO; full drops captured words and raises overflow
	// ----------------------------------------------------------------
	cli_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_valid  (cap_ok),
		.in_ready  (fifo_ready),
		.in_data   (data_s), // R2
		.out_ready (fifo_pop),
		.out_valid (fifo_ovalid),
		.out_data  (fifo_odata),
		.level     (fifo_level)
	);

	// ----------------------------------------------------------------
	// Trigger, control and master-clock outputs
	// ----------------------------------------------------------------
	logic [3:0]  tout_ff, nxt_tout, ctl_ff, nxt_ctl, ev_sel;
	logic [15:0] mcnt_ff [2];
	logic [15:0] nxt_mcnt [2];
	logic [1:0]  mclk_ff, nxt_mclk;
	logic        status_ev;

	always_comb begin
		case (tcfg_ff[cli_pkg::TRIG_EVSEL +: 2])
			2'h0:    status_ev = (st_ff != cli_pkg::ST_IDLE);
			2'h1:    status_ev = act[0];
			2'h2:    status_ev = fifo_wr;
			default: status_ev = fifo_ovalid;
		endcase
	end

	// Per-line output source, direction gating the drive
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_line
			always_comb begin
				case (tcfg_ff[cli_pkg::TRIG_MODE + 2*gi +: 2])
					cli_pkg::TMODE_STATUS: ev_sel[gi] = status_ev; // R7
					cli_pkg::TMODE_PULSE:  ev_sel[gi] = pulse_act; // R7
					default:               ev_sel[gi] = tcfg_ff[cli_pkg::TRIG_LVL + gi]; // R7
				endcase
				nxt_tout[gi] = tdir[gi] && ev_sel[gi]; // R11
				nxt_ctl[gi]  = ctlo_ff[cli_pkg::CTLO_DYN + gi] ? pulse_act
					: ctlo_ff[cli_pkg::CTLO_LVL + gi]; // R9
			end
		end
	endgenerate

	// Half-period counters; the 40 MHz ceiling is out of reach at this clock
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			nxt_mcnt[i] = (mcnt_ff[i] >= mdiv_ff[i]) ? 16'h0000 : 16'(mcnt_ff[i] + 16'h0001);
			nxt_mclk[i] = (mcnt_ff[i] >= mdiv_ff[i]) ? !mclk_ff[i] : mclk_ff[i]; // R8
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tout_ff    <= 4'h0;
			ctl_ff     <= 4'h0;
			mcnt_ff[0] <= 16'h0000;
			mcnt_ff[1] <= 16'h0000;
			mclk_ff    <= 2'h0;
		end else begin
			tout_ff    <= nxt_tout;
			ctl_ff     <= nxt_ctl;
			mcnt_ff    <= nxt_mcnt;
			mclk_ff    <= nxt_mclk;
		end
	end

	assign trig_out = tout_ff;
	assign trig_oe  = tdir; // R11
	assign cam_ctl  = ctl_ff;
	assign cam_mclk = mclk_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_pix_on_edge: assert property (fifo_wr |-> pclk_s && $past(pclk_s) == 1'b0) // R1
		else $error("word captured without a pixel clock edge");
	a_one_word_edge: assert property (fifo_wr |=> !fifo_wr) // R2
		else $error("two words from one pixel clock edge");
	a_enable_qual: assert property (fifo_wr |-> act[0] && act[1] && qual_ok) // R3
		else $error("word captured outside the enables");
	a_trig_starts: assert property ((st_ff == cli_pkg::ST_IDLE) && (|trig_hit) // R5
		|=> st_ff == cli_pkg::ST_WAIT)
		else $error("trigger edge did not arm acquisition");
	a_edge_select: assert property (trig_hit[0] |-> (tcfg_ff[cli_pkg::TRIG_FALL] // R6
		? $fell(trig_s[0]) : $rose(trig_s[0])))
		else $error("trigger taken on the wrong edge");
	a_trig_level: assert property (tdir[1] && tcfg_ff[cli_pkg::TRIG_MODE+2 +: 2] == 2'h0 // R7
		|=> trig_out[1] == $past(tcfg_ff[cli_pkg::TRIG_LVL + 1]))
		else $error("trigger output level wrong");
	a_trig_pulse: assert property (tdir[2] && tcfg_ff[cli_pkg::TRIG_MODE+4 +: 2] == 2'h2 // R7
		|=> trig_out[2] == $past(pulse_act))
		else $error("trigger output pulse wrong");
	a_mclk_rate: assert property ($changed(cam_mclk[0]) // R8
		|-> $past(mcnt_ff[0]) >= $past(mdiv_ff[0]))
		else $error("master clock toggled early");
	// Line 3 is the one the bench puts in pulse mode
	a_ctl_source: assert property (ctlo_ff[cli_pkg::CTLO_DYN + 3] // R9
		##1 ctlo_ff[cli_pkg::CTLO_DYN + 3] |-> cam_ctl[3] == $past(pulse_act))
		else $error("control line not following pulse");
	a_window_start: assert property (fifo_wr |-> pix_cur >= wstart_ff[15:0] // R10
		&& nxt_line >= wstart_ff[31:16])
		else $error("word captured before window start");
	// An output line ignores its pin and an input line is never driven
	a_out_no_start: assert property ((trig_oe[3] |-> !trig_hit[3]) // R11
		and (!trig_oe[3] |=> trig_out[3] == 1'b0))
		else $error("output line took a start edge");
endmodule

/* File: sim/cli_cam_model.sv */
// Behavioural camera that drives pixel clock, pixel data and enables.
// Assumes the bench calls frame() while the board waits for a frame.
`timescale 1ns/1ns
module cli_cam_model (
	// Camera pins toward the board
	output logic        cam_pclk,
	output logic [15:0] cam_data,
	output logic [3:0]  cam_ena
);
	// ----------------------------------------------------------------
	// Idle levels
	// ----------------------------------------------------------------
	// Pixel clock stands still outside frames; field line C is held low
	initial begin
		cam_pclk = 1'b0;
		cam_data = 16'h5a5a;
		cam_ena  = 4'h0;
	end

	// One frame of nl lines by np pixels, word = base + line*16 + pixel
	// Data changes at pixel clock fall, so it is stable around each rise
	task automatic frame(input int nl, input int np, input logic [15:0] base);
		cam_ena[0] = 1'b1;
		#320;
		for (int l = 0; l < nl; l++) begin
			for (int p = 0; p < np; p++) begin
				cam_ena[1] = 1'b1;
				cam_data   = base + 16'(l * 16 + p);
				#160 cam_pclk = 1'b1;
				#160 cam_pclk = 1'b0;
			end
			// Released data shows the inverse; a blanking edge shows the line end
			cam_ena[1] = 1'b0;
			cam_data   = ~cam_data;
			#160 cam_pclk = 1'b1;
			#160 cam_pclk = 1'b0;
		end
		// Enables are only seen on pixel clock edges, so two trailing edges end the frame
		cam_ena[0] = 1'b0;
		repeat (2) begin
			#160 cam_pclk = 1'b1;
			#160 cam_pclk = 1'b0;
		end
	endtask
endmodule

/* File: sim/cli_io_test.sv */
// Self-checking bench for the camera pixel, trigger and clock block.
// Assumes the camera model in cli_cam_model.sv; triggers driven here.
`timescale 1ns/1ns
module cli_io_test;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        cam_pclk;
	logic [15:0] cam_data;
	logic [3:0]  cam_ena;
	logic [3:0]  cam_ctl;
	logic [1:0]  cam_mclk;
	logic [3:0]  trig_in = 4'h0;
	logic [3:0]  trig_out;
	logic [3:0]  trig_oe;
	int          num_errors = 0;
	int          cmp_count = 0;
	logic        mon = 1'b0;
	int          n_tp, n_cc, n_ta;
	logic [31:0] v;
	int          n;

	cli_io dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cam_pclk(cam_pclk),
		.cam_data(cam_data), .cam_ena(cam_ena), .cam_ctl(cam_ctl), .cam_mclk(cam_mclk),
		.trig_in(trig_in), .trig_out(trig_out), .trig_oe(trig_oe));
	cli_cam_model cam_u (.cam_pclk(cam_pclk), .cam_data(cam_data), .cam_ena(cam_ena));

	// 25 MHz clock
	initial begin
		forever #20 clk = ~clk;
	end

	// Pulse and status counters, enabled only around a frame
	always @(posedge clk) begin
		if (mon) begin
			n_tp += int'(trig_out[2] === 1'b1);
			n_cc += int'(cam_ctl[3] === 1'b1);
			n_ta += int'(trig_out[1] === 1'b1);
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results;
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Reset is held 8 cycles, which also flushes the synchronisers
	task automatic do_reset;
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask

	// Length in clk cycles of the next high phase of a master clock
	task automatic mhi(input int i, output int len);
		len = 0;
		repeat (60) begin
			@(negedge clk);
			if (cam_mclk[i] === 1'b0) break;
		end
		repeat (60) begin
			@(negedge clk);
			if (cam_mclk[i] === 1'b1) break;
		end
		while (cam_mclk[i] === 1'b1 && len < 60) begin
			@(negedge clk);
			len++;
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		do_reset();
		check(32'({cam_ctl, cam_mclk, trig_out, trig_oe}), 32'h0000_0000);
		rd(cli_pkg::REG_MCLK0, v);
		check(v, 32'h0000_0018);
		rd(cli_pkg::REG_WCOUNT, v);
		check(v, 32'hffff_ffff);
		wr(8'h40, 32'hffff_ffff);
		rd(8'h40, v);
		check(v, 32'h0000_0000);
		$display("reset test done");
	endtask

	// Window of lines 1..2, pixels 1..2 out of a 3 by 4 frame
	task automatic t_window;
		do_reset();
		wr(cli_pkg::REG_WSTART, 32'h0001_0001);
		wr(cli_pkg::REG_WCOUNT, 32'h0002_0002);
		wr(cli_pkg::REG_CTRL, 32'h0000_0002);
		rd(cli_pkg::REG_STATUS, v);
		check(v & 32'h0000_0003, 32'h0000_0001);
		cam_u.frame(3, 4, 16'h1000);
		rd(cli_pkg::REG_STATUS, v);
		check(v & 32'h0000_0003, 32'h0000_0000);
		rd(cli_pkg::REG_DATA, v);
		check(v, 32'h0001_1011);
		rd(cli_pkg::REG_DATA, v);
		check(v, 32'h0001_1012);
		rd(cli_pkg::REG_DATA, v);
		check(v, 32'h0001_1021);
		rd(cli_pkg::REG_DATA, v);
		check(v, 32'h0001_1022);
		rd(cli_pkg::REG_DATA, v);
		check(v & 32'h0001_0000, 32'h0000_0000);
		$display("window test done");
	endtask

	// Falling-edge start on trigger 0: a rise must not start anything
	task automatic t_trig_in;
		do_reset();
		wr(cli_pkg::REG_TRIG, 32'h0000_0010);
		wr(cli_pkg::REG_CTRL, 32'h0000_0010);
		@(posedge clk) trig_in <= 4'h1;
		repeat (8) @(posedge clk);
		rd(cli_pkg::REG_STATUS, v);
		check(v & 32'h0000_0003, 32'h0000_0000);
		check(32'(trig_oe), 32'h0000_0000);
		@(posedge clk) trig_in <= 4'h0;
		repeat (8) @(posedge clk);
		rd(cli_pkg::REG_STATUS, v);
		check(v & 32'h0000_0003, 32'h0000_0001);
		$display("trigger input test done");
	endtask

	// Level, status and pulse outputs; dynamic control line 3
	task automatic t_trig_out;
		do_reset();
		wr(cli_pkg::REG_PULSE, 32'h0000_0005);
		wr(cli_pkg::REG_CTLOUT, 32'h0000_0081);
		wr(cli_pkg::REG_TRIG, 32'h0002_410f);
		repeat (3) @(negedge clk);
		check(32'({trig_oe, trig_out}), 32'h0000_00f1);
		check(32'(cam_ctl), 32'h0000_0001);
		wr(cli_pkg::REG_CTRL, 32'h0000_0002);
		n_tp = 0;
		n_cc = 0;
		n_ta = 0;
		mon = 1'b1;
		cam_u.frame(2, 3, 16'h2000);
		mon = 1'b0;
		check(32'(n_tp), 32'h0000_0005);
		check(32'(n_cc), 32'h0000_0005);
		check(32'(n_ta > 0), 32'h0000_0001);
		wr(cli_pkg::REG_TRIG, 32'h0000_0f00);
		repeat (3) @(negedge clk);
		check(32'({trig_oe, trig_out}), 32'h0000_0000);
		$display("trigger output test done");
	endtask

	// Divisor 2 gives 3 cycles high; 30 clamps to 24, 25 cycles high
	task automatic t_mclk;
		do_reset();
		wr(cli_pkg::REG_MCLK0, 32'h0000_0002);
		wr(cli_pkg::REG_MCLK1, 32'h0000_001e);
		rd(cli_pkg::REG_MCLK1, v);
		check(v, 32'h0000_0018);
		mhi(0, n);
		check(32'(n), 32'h0000_0003);
		mhi(1, n);
		check(32'(n), 32'h0000_0019);
		$display("master clock test done");
	endtask

	// 20 words with no reads: 17 kept, overflow set, then drained; field match on
	task automatic t_fill;
		do_reset();
		wr(cli_pkg::REG_CTRL, 32'h0000_0006);
		cam_u.frame(1, 20, 16'h3000);
		rd(cli_pkg::REG_STATUS, v);
		check(v & 32'h0001_f804, 32'h0000_8804);
		for (int k = 0; k < 17; k++) begin
			rd(cli_pkg::REG_DATA, v);
			check(v, 32'h0001_3000 + 32'(k));
		end
		rd(cli_pkg::REG_DATA, v);
		check(v & 32'h0001_0000, 32'h0000_0000);
		wr(cli_pkg::REG_STATUS, 32'h0000_0004);
		rd(cli_pkg::REG_STATUS, v);
		check(v & 32'h0000_0004, 32'h0000_0000);
		$display("fill test done");
	endtask

	// ----------------------------------------------------------------
	// Sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		t_reset();
		t_window();
		t_trig_in();
		t_trig_out();
		t_mclk();
		t_fill();
		results();
	end

	// Whole run takes well under 200 us; 2 ms means a hang
	initial begin
		#2_000_000;
		num_errors++;
		results();
	end
endmodule
